// ===== verilog/sgpio_bank.sv
// GPIO bank behind a locked index/data configuration port pair
`timescale 1ns/1ps
`default_nettype none
module sgpio_bank (
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       IO_WR_IN,
  input  wire logic       IO_RD_IN,
  input  wire logic [7:0] IO_ADDR_IN,
  input  wire logic [7:0] IO_WDATA_IN,
  output var  logic [7:0] IO_RDATA_OUT,
  output var  logic       CFG_OPEN_OUT,
  input  wire logic [7:0] PIN_IN,
  output var  logic [7:0] PIN_OUT,
  output var  logic [7:0] PIN_OE_OUT
);
  sgpio_pkg::sgpio_io_t   io;
  sgpio_pkg::sgpio_mode_t mode_q;
  sgpio_pkg::sgpio_mode_t mode_d;
  sgpio_pkg::sgpio_regs_t regs_q;
  sgpio_pkg::sgpio_regs_t regs_d;
  logic [7:0] index_q;
  logic [7:0] index_d;
  logic [7:0] ldev_q;
  logic [7:0] ldev_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] pin_q;
  logic [7:0] pin_d;
  logic [7:0] oe_q;
  logic [7:0] oe_d;
  logic [7:0] pin_sync;
  logic [7:0] pin_seen;
  logic [7:0] data_view;
  logic       idx_wr;
  logic       dat_wr;
  logic       dat_rd;
  logic       gpio_sel;
  logic       en_sel;
  logic       bank_on;
  logic       open_q;
  logic       open_d;
  logic [7:0] data_merge;
  logic [7:0] oe_bits;
  logic [7:0] drv_bits;

  assign io = '{wr: IO_WR_IN, rd: IO_RD_IN, addr: IO_ADDR_IN, wdata: IO_WDATA_IN};

  // Pins are asynchronous to the bus clock
  sgpio_pin_sync u_sync (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .async_in (PIN_IN),
    .sync_out (pin_sync)
  );

  assign idx_wr   = io.wr && (io.addr == sgpio_pkg::SGPIO_IDX_PORT);
  assign dat_wr   = io.wr && (io.addr == sgpio_pkg::SGPIO_DATA_PORT) &&
                    (mode_q == sgpio_pkg::SGPIO_OPEN);
  assign dat_rd   = io.rd && (io.addr == sgpio_pkg::SGPIO_DATA_PORT) &&
                    (mode_q == sgpio_pkg::SGPIO_OPEN);
  assign gpio_sel = (ldev_q == sgpio_pkg::SGPIO_LDEV_GPIO);
  assign en_sel   = (ldev_q == sgpio_pkg::SGPIO_LDEV_ENABLE);
  assign bank_on  = regs_q.enable[sgpio_pkg::SGPIO_EN_BIT];

  // Per-pin paths; input bits show the pin after the inversion mask, output bits the stored value
  for (genvar b = 0; b < $bits(PIN_IN); b++) begin : g_pin
    assign pin_seen[b]   = pin_sync[b] ^ regs_q.inv[b];
    assign data_view[b]  = regs_q.dir[b] ? pin_seen[b] : regs_q.data[b];
    // Input bits keep their stored value so a later direction flip is clean
    assign data_merge[b] = regs_q.dir[b] ? regs_q.data[b] : io.wdata[b];
    assign oe_bits[b]    = bank_on & ~regs_q.dir[b];
    assign drv_bits[b]   = regs_q.data[b] ^ regs_q.inv[b];
  end

  // Key sequence; any other index write between the two keys restarts it
  always_comb begin
    mode_d = mode_q;
    if (idx_wr) begin
      case (mode_q)
        sgpio_pkg::SGPIO_LOCKED: begin
          if (io.wdata == sgpio_pkg::SGPIO_KEY_ENTER) mode_d = sgpio_pkg::SGPIO_HALF_KEY;
        end
        sgpio_pkg::SGPIO_HALF_KEY: begin
          mode_d = (io.wdata == sgpio_pkg::SGPIO_KEY_ENTER) ?
                   sgpio_pkg::SGPIO_OPEN : sgpio_pkg::SGPIO_LOCKED;
        end
        sgpio_pkg::SGPIO_OPEN: begin
          if (io.wdata == sgpio_pkg::SGPIO_KEY_EXIT) mode_d = sgpio_pkg::SGPIO_LOCKED;
        end
        default: mode_d = sgpio_pkg::SGPIO_LOCKED;
      endcase
    end
    open_d = (mode_d == sgpio_pkg::SGPIO_OPEN);
  end

  // Open flag taken from the next state so it lines up with mode_q
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q <= sgpio_pkg::SGPIO_LOCKED;
      open_q <= '0;
    end else begin
      mode_q <= mode_d;
      open_q <= open_d;
    end
  end

  // Index and register writes
  always_comb begin
    index_d = index_q;
    ldev_d  = ldev_q;
    regs_d  = regs_q;
    if (idx_wr && (mode_q == sgpio_pkg::SGPIO_OPEN) &&
        (io.wdata != sgpio_pkg::SGPIO_KEY_EXIT)) begin
      index_d = io.wdata;
    end
    if (dat_wr) begin
      case (index_q)
        sgpio_pkg::SGPIO_IDX_LDSEL: begin
          ldev_d = io.wdata;
        end
        sgpio_pkg::SGPIO_IDX_ENABLE: begin
          if (en_sel) regs_d.enable = io.wdata;
        end
        sgpio_pkg::SGPIO_IDX_DIR: begin
          if (gpio_sel) regs_d.dir = io.wdata;
        end
        sgpio_pkg::SGPIO_IDX_DATA: begin
          if (gpio_sel) regs_d.data = data_merge;
        end
        sgpio_pkg::SGPIO_IDX_INV: begin
          if (gpio_sel) regs_d.inv = io.wdata;
        end
        // Unmapped indexes take no write
        default: begin
        end
      endcase
    end
  end

  // Read data stands one cycle, idle value otherwise
  always_comb begin
    rdata_d = sgpio_pkg::SGPIO_READ_IDLE;
    if (dat_rd) begin
      case (index_q)
        sgpio_pkg::SGPIO_IDX_LDSEL: begin
          rdata_d = ldev_q;
        end
        sgpio_pkg::SGPIO_IDX_ENABLE: begin
          if (en_sel) rdata_d = regs_q.enable;
        end
        sgpio_pkg::SGPIO_IDX_DIR: begin
          if (gpio_sel) rdata_d = regs_q.dir;
        end
        sgpio_pkg::SGPIO_IDX_DATA: begin
          if (gpio_sel) rdata_d = data_view;
        end
        sgpio_pkg::SGPIO_IDX_INV: begin
          if (gpio_sel) rdata_d = regs_q.inv;
        end
        // Unmapped indexes read the idle value
        default: begin
        end
      endcase
    end
  end

  // Pin drivers; disabled bank floats every pin
  always_comb begin
    oe_d  = oe_bits;
    pin_d = drv_bits;
  end

  // Configuration survives mode exit; only reset clears it
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      index_q       <= sgpio_pkg::SGPIO_RST_INDEX;
      ldev_q        <= sgpio_pkg::SGPIO_RST_LDEV;
      regs_q.enable <= sgpio_pkg::SGPIO_RST_ENABLE;
      regs_q.dir    <= sgpio_pkg::SGPIO_RST_DIR;
      regs_q.data   <= sgpio_pkg::SGPIO_RST_DATA;
      regs_q.inv    <= sgpio_pkg::SGPIO_RST_INV;
    end else begin
      index_q <= index_d;
      ldev_q  <= ldev_d;
      regs_q  <= regs_d;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= sgpio_pkg::SGPIO_READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Registered so the pins never see decode glitches
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_q <= '0;
      oe_q  <= '0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign IO_RDATA_OUT = rdata_q;
  assign CFG_OPEN_OUT = open_q;
  assign PIN_OUT      = pin_q;
  assign PIN_OE_OUT   = oe_q;
endmodule : sgpio_bank
`default_nettype wire

// ===== verilog/sgpio_pkg.sv
// Package: constants and carrier types for the configuration-port GPIO bank
package sgpio_pkg;
  localparam logic [7:0] SGPIO_IDX_PORT     = 8'h2e;
  localparam logic [7:0] SGPIO_DATA_PORT    = 8'h2f;
  localparam logic [7:0] SGPIO_KEY_ENTER    = 8'h87;
  localparam logic [7:0] SGPIO_KEY_EXIT     = 8'haa;
  localparam logic [7:0] SGPIO_IDX_LDSEL    = 8'h07;
  localparam logic [7:0] SGPIO_IDX_ENABLE   = 8'h30;
  localparam logic [7:0] SGPIO_IDX_DIR      = 8'he0;
  localparam logic [7:0] SGPIO_IDX_DATA     = 8'he1;
  localparam logic [7:0] SGPIO_IDX_INV      = 8'he2;
  localparam logic [7:0] SGPIO_LDEV_GPIO    = 8'h07;
  localparam logic [7:0] SGPIO_LDEV_ENABLE  = 8'h09;
  localparam int         SGPIO_EN_BIT       = 7;
  localparam logic [7:0] SGPIO_RST_ENABLE   = 8'h00;
  localparam logic [7:0] SGPIO_RST_DIR      = 8'hff;
  localparam logic [7:0] SGPIO_RST_DATA     = 8'h00;
  localparam logic [7:0] SGPIO_RST_INV      = 8'h00;
  localparam logic [7:0] SGPIO_RST_LDEV     = 8'h00;
  localparam logic [7:0] SGPIO_RST_INDEX    = 8'h00;
  localparam logic [7:0] SGPIO_READ_IDLE    = 8'hff;

  typedef enum logic [1:0] {
    SGPIO_LOCKED,
    SGPIO_HALF_KEY,
    SGPIO_OPEN
  } sgpio_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgpio_io_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] inv;
  } sgpio_regs_t;
endpackage : sgpio_pkg

// ===== verilog/sgpio_pin_sync.sv
// Two-flop synchroniser for the pin inputs of the bank
`timescale 1ns/1ps
`default_nettype none
module sgpio_pin_sync (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] async_in,
  output var  logic [7:0] sync_out
);
  logic [7:0] meta_q;
  logic [7:0] meta_d;
  logic [7:0] sync_q;
  logic [7:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : sgpio_pin_sync
`default_nettype wire

// ===== verification/sgpio_pin_model.sv
// Pin-side model of the board wiring
`timescale 1ns/1ps
`default_nettype none
module sgpio_pin_model (
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] ext_in,
  output var  logic [7:0] level_out
);
  // Undriven pins follow the board level, never a stale drive
  assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule : sgpio_pin_model
`default_nettype wire

// ===== verification/sgpio_bank_asserts.sv
// Port checker for the GPIO bank
`timescale 1ns/1ps
`default_nettype none
module sgpio_bank_asserts (
  input wire logic       CLOCK_IN,
  input wire logic       RST_N_IN,
  input wire logic       IO_WR_IN,
  input wire logic       IO_RD_IN,
  input wire logic [7:0] IO_ADDR_IN,
  input wire logic [7:0] IO_WDATA_IN,
  input wire logic [7:0] IO_RDATA_OUT,
  input wire logic       CFG_OPEN_OUT,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE_OUT
);
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  wire wr_idx = IO_WR_IN && IO_ADDR_IN == 8'h2e;
  wire k87    = wr_idx && IO_WDATA_IN == 8'h87;
  wire kaa    = wr_idx && IO_WDATA_IN == 8'haa;
  wire wr_dp  = IO_WR_IN && IO_ADDR_IN == 8'h2f && CFG_OPEN_OUT;
  chk_idle_read: assert property (
    !IO_RD_IN |=> IO_RDATA_OUT == 8'hff) else $error("Idle read data wrong");
  chk_locked_read: assert property (
    !CFG_OPEN_OUT && IO_RD_IN && IO_ADDR_IN == 8'h2f |=> IO_RDATA_OUT == 8'hff)
    else $error("Locked read not idle");
  chk_key_open: assert property (
    !CFG_OPEN_OUT && k87 ##1 k87 |=> CFG_OPEN_OUT) else $error("Key did not open");
  chk_stay_locked: assert property (
    !CFG_OPEN_OUT && !k87 |=> !CFG_OPEN_OUT) else $error("Opened without key");
  chk_key_exit: assert property (
    CFG_OPEN_OUT && kaa |=> !CFG_OPEN_OUT) else $error("Exit key ignored");
  chk_stay_open: assert property (
    CFG_OPEN_OUT && !kaa |=> CFG_OPEN_OUT) else $error("Closed without key");
  // Pin drive follows a data write by two edges
  chk_pin_hold: assert property (
    !wr_dp ##1 !wr_dp |=> $stable(PIN_OUT)) else $error("Pin drive changed unasked");
  chk_oe_hold: assert property (
    !wr_dp ##1 !wr_dp |=> $stable(PIN_OE_OUT)) else $error("Pin enable changed unasked");
endmodule : sgpio_bank_asserts
bind sgpio_bank sgpio_bank_asserts u_sgpio_bank_asserts (.CLOCK_IN(CLOCK_IN),
  .RST_N_IN(RST_N_IN), .IO_WR_IN(IO_WR_IN), .IO_RD_IN(IO_RD_IN), .IO_ADDR_IN(IO_ADDR_IN),
  .IO_WDATA_IN(IO_WDATA_IN), .IO_RDATA_OUT(IO_RDATA_OUT), .CFG_OPEN_OUT(CFG_OPEN_OUT),
  .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT));
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the GPIO bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, open_o;
  logic [7:0]  ad = 0, wd = 0, ext = 0, rdata, pin, pout, poe;
  logic [31:0] lf = 32'h0248;
  int          err_total = 0, total_checks = 0;
  always #10 clk = ~clk;
  sgpio_bank u_sgpio_bank (.CLOCK_IN(clk), .RST_N_IN(rst_n), .IO_WR_IN(wr), .IO_RD_IN(rd),
    .IO_ADDR_IN(ad), .IO_WDATA_IN(wd), .IO_RDATA_OUT(rdata), .CFG_OPEN_OUT(open_o),
    .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE_OUT(poe));
  sgpio_pin_model u_sgpio_pin_model (.drive_in(pout), .oe_in(poe), .ext_in(ext),
    .level_out(pin));
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction : rnd
  // Input bits show the inverted pin, output bits the stored value
  function automatic logic [7:0] exp_rd(logic [7:0] dir, inv, d, e);
    return ((e ^ inv) & dir) | (d & ~dir);
  endfunction : exp_rd
  task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic io(logic w, logic [7:0] a, d);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    ad = a;
    wd = d;
    @(posedge clk);
    #1;
    wr = 0;
    rd = 0;
  endtask : io
  task automatic rw(logic [7:0] i, v);
    io(1, 8'h2e, i);
    io(1, 8'h2f, v);
  endtask : rw
  task automatic rchk(string nm, logic [7:0] i, exp);
    io(1, 8'h2e, i);
    io(0, 8'h2f, 8'h00);
    cmp(nm, exp, rdata);
  endtask : rchk
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  initial begin
    logic [7:0] dir, inv, d, en;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    io(1, 8'h2f, 8'h55);
    rchk("locked", 8'he1, 8'hff);
    // Broken key sequence must not open
    io(1, 8'h2e, 8'h87);
    io(1, 8'h2e, 8'h07);
    io(1, 8'h2e, 8'h87);
    cmp("half", 8'h00, {7'h0, open_o});
    io(1, 8'h2e, 8'h87);
    cmp("open", 8'h01, {7'h0, open_o});
    rw(8'h07, 8'h07);
    rw(8'he0, 8'h00);
    // Enables register one edge behind the write
    @(posedge clk);
    #1;
    cmp("oe_off", 8'h00, poe);
    rchk("ldev", 8'h30, 8'hff);
    rw(8'h07, 8'h09);
    rchk("en_rst", 8'h30, 8'h00);
    en = rnd() | 8'h80;
    rw(8'h30, en);
    rchk("en", 8'h30, en);
    rw(8'h07, 8'h07);
    cmp("oe_on", 8'hff, poe);
    repeat (6) begin
      dir = rnd();
      inv = rnd();
      d = rnd();
      ext = rnd();
      rw(8'he0, dir);
      rw(8'he2, inv);
      rw(8'he1, d);
      rchk("dir", 8'he0, dir);
      rchk("inv", 8'he2, inv);
      rchk("data", 8'he1, exp_rd(dir, inv, d, ext));
      cmp("oe", ~dir, poe);
      cmp("pin", (d ^ inv) & ~dir, pout & poe);
      rw(8'he1, ~d);
      rchk("data2", 8'he1, exp_rd(dir, inv, ~d, ext));
    end
    rchk("unmapped", 8'h31, 8'hff);
    io(1, 8'h2e, 8'haa);
    cmp("exit", 8'h00, {7'h0, open_o});
    rchk("closed", 8'he1, 8'hff);
    // Back-to-back keys, strobe held over two edges
    @(posedge clk);
    #1;
    wr = 1;
    ad = 8'h2e;
    wd = 8'h87;
    repeat (2) @(posedge clk);
    #1;
    wr = 0;
    cmp("reopen", 8'h01, {7'h0, open_o});
    stop_test();
  end
endmodule : testbench
`default_nettype wire
